// ### design/tsi2c_regfile.v
// Register bank written and read through the serial port
`timescale 1ns/100ps
`include "tsi2c_map.vh"
module tsi2c_regfile #(
    parameter AW = 8,
    parameter DEPTH = 256
) (
    input wire clock_in,
    input wire resetn_in,
    input wire enable_in,
    input wire wr_in,
    input wire [AW-1:0] waddr_in,
    input wire [7:0] wdata_in,
    input wire [AW-1:0] raddr_in,
    output wire [7:0] rdata_out
);
    reg [7:0] mem [0:DEPTH-1];
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_reg
            always @(posedge clock_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    mem[i] <= `TSI2C_REG_RESET;
                end else if (enable_in && wr_in && waddr_in == i) begin
                    mem[i] <= wdata_in;
                end
            end
        end
    endgenerate
    assign rdata_out = mem[raddr_in];
endmodule // tsi2c_regfile

// ### design/tsi2c_slave.v
// Two-wire serial slave port of the touch sensor controller
`timescale 1ns/100ps
`include "tsi2c_map.vh"
module tsi2c_slave #(
    parameter [6:0] SLAVE_ADDR = `TSI2C_ADDR_A,
    parameter AW = 8
) (
    input wire clock_in,
    input wire resetn_in,
    input wire enable_in,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n_out,
    output reg busy_out,
    output reg [AW-1:0] pointer_out
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RECV = 5'h02;
    localparam [4:0] ST_ACK = 5'h04;
    localparam [4:0] ST_SEND = 5'h08;
    localparam [4:0] ST_MACK = 5'h10;

    wire scl_s;
    wire sda_s;
    reg scl_d;
    reg sda_d;
    reg [4:0] state;
    reg [7:0] shift;
    reg [3:0] bitcnt;
    reg [1:0] phase;
    reg rw;
    reg drive_low;
    reg wr_pulse;
    reg [AW-1:0] wr_addr;
    reg [7:0] wr_data;
    wire [7:0] rd_data;
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    localparam [1:0] PH_ADDR = 2'd0;
    localparam [1:0] PH_CMD = 2'd1;
    localparam [1:0] PH_DATA = 2'd2;

    // Pins come from the master's domain, so both pass two flip-flops
    tsi2c_sync u_scl_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .enable_in(enable_in),
        .async_in(scl_in),
        .sync_out(scl_s)
    );
    tsi2c_sync u_sda_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .enable_in(enable_in),
        .async_in(sda_in),
        .sync_out(sda_s)
    );

    tsi2c_regfile #(
        .AW(AW),
        .DEPTH(1 << AW)
    ) u_regs (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .enable_in(enable_in),
        .wr_in(wr_pulse),
        .waddr_in(wr_addr),
        .wdata_in(wr_data),
        .raddr_in(pointer_out),
        .rdata_out(rd_data)
    );

    // 25 MHz sampling gives about 62 samples per bit at 400 kbit/s
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (enable_in) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s;
    assign stop_cond = scl_s && scl_d && !sda_d && sda_s;

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bitcnt <= 4'h0;
            phase <= PH_ADDR;
            rw <= 1'b0;
            drive_low <= 1'b0;
            wr_pulse <= 1'b0;
            wr_addr <= {AW{1'b0}};
            wr_data <= 8'h00;
            pointer_out <= `TSI2C_PTR_RESET;
            busy_out <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else if (enable_in) begin
            wr_pulse <= 1'b0;
            // Open drain: output level fixed low, only the enable moves
            sda_out <= 1'b0;
            sda_oe_n_out <= !drive_low;
            if (start_cond) begin
                // Repeated START also lands here and keeps the pointer
                state <= ST_RECV;
                phase <= PH_ADDR;
                bitcnt <= 4'h0;
                drive_low <= 1'b0;
                busy_out <= 1'b1;
            end else if (stop_cond) begin
                state <= ST_IDLE;
                drive_low <= 1'b0;
                busy_out <= 1'b0;
            end else begin
                case (state)
                ST_IDLE: begin
                    drive_low <= 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall &&
                                 bitcnt == `TSI2C_BITS_PER_BYTE) begin
                        bitcnt <= 4'h0;
                        state <= ST_ACK;
                        drive_low <= 1'b1;
                        case (phase)
                        PH_ADDR: begin
                            if (shift[7:1] == SLAVE_ADDR) begin
                                rw <= shift[`TSI2C_RW_BIT];
                            end else begin
                                state <= ST_IDLE;
                                drive_low <= 1'b0;
                            end
                        end
                        PH_CMD: begin
                            pointer_out <= shift[AW-1:0];
                        end
                        default: begin
                            wr_pulse <= 1'b1;
                            wr_addr <= pointer_out;
                            wr_data <= shift;
                            pointer_out <= pointer_out + 1'b1;
                        end
                        endcase
                    end
                end
                ST_ACK: begin
                    // After the ninth clock's falling edge release, or for a read drive data bit 7
                    if (scl_fall) begin
                        if (phase == PH_ADDR && rw) begin
                            state <= ST_SEND;
                            shift <= rd_data;
                            drive_low <= !rd_data[7];
                            pointer_out <= pointer_out + 1'b1;
                            bitcnt <= 4'h1;
                        end else begin
                            state <= ST_RECV;
                            drive_low <= 1'b0;
                            phase <= (phase == PH_ADDR) ? PH_CMD : PH_DATA;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (bitcnt == `TSI2C_BITS_PER_BYTE) begin
                            state <= ST_MACK;
                            drive_low <= 1'b0;
                        end else begin
                            drive_low <= !shift[7 - bitcnt[2:0]];
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        // Master's NACK ends the read; it must then STOP
                        if (sda_s) begin
                            state <= ST_IDLE;
                        end else begin
                            shift <= rd_data;
                            bitcnt <= 4'h0;
                        end
                    end else if (scl_fall && bitcnt == 4'h0) begin
                        state <= ST_SEND;
                        drive_low <= !shift[7];
                        pointer_out <= pointer_out + 1'b1;
                        bitcnt <= 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    drive_low <= 1'b0;
                end
                endcase
            end
        end
    end
endmodule // tsi2c_slave

// ### design/tsi2c_sync.v
// Two flip-flop synchroniser for the serial pins
`timescale 1ns/100ps
module tsi2c_sync (
    input wire clock_in,
    input wire resetn_in,
    input wire enable_in,
    input wire async_in,
    output reg sync_out
);
    reg meta;
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta <= 1'b1;
            sync_out <= 1'b1;
        end else if (enable_in) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // tsi2c_sync

// ### shared/tsi2c_map.vh
// Constants for the touch sensor two-wire slave port
`ifndef TSI2C_MAP_VH
`define TSI2C_MAP_VH
`define TSI2C_ADDR_A 7'h4a
`define TSI2C_ADDR_B 7'h4b
`define TSI2C_RW_BIT 0
`define TSI2C_BITS_PER_BYTE 4'h8
`define TSI2C_MAX_RATE_KBPS 400
`define TSI2C_CLK_MHZ 25
`define TSI2C_SYNC_STAGES 2
`define TSI2C_PTR_RESET 8'h00
`define TSI2C_REG_RESET 8'h00
`endif

// ### tb/touch_sensor_i2c_slave_tb_top.sv
// Self-checking bench for the touch sensor serial slave port
`timescale 1ns/100ps
module touch_sensor_i2c_slave_tb_top;
    reg clock_in;
    reg resetn_in;
    reg enable_in;
    reg [7:0] rx;
    reg ack;
    wire scl;
    wire m_low;
    wire sda_out;
    wire sda_oe_n_out;
    wire busy_out;
    wire [7:0] pointer_out;
    // Pull-up: the line is low only while a party pulls it
    wire sda = !(m_low || (!sda_oe_n_out && !sda_out));
    integer num_errors = 0;
    integer samples_checked = 0;
    tsi2c_slave #(.SLAVE_ADDR(7'h4a), .AW(8)) dut (.clock_in(clock_in),
        .resetn_in(resetn_in), .enable_in(enable_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
        .busy_out(busy_out), .pointer_out(pointer_out));
    tsi2c_master m (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = !clock_in;
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wb(input [7:0] b, input e);
        begin
            m.xfer(b, 1'b1, rx, ack);
            chk(ack, e);
        end
    endtask
    task rb(input mack, input [7:0] e);
        begin
            m.xfer(8'hff, mack, rx, ack);
            chk(rx, e);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task t_idle;
        begin
            chk(sda_oe_n_out, 1);
            chk(busy_out, 0);
            chk(pointer_out, 8'h00);
            enable_in = 1'b0;
            repeat (5) @(posedge clock_in);
            #1 enable_in = 1'b1;
            $display("test idle done");
        end
    endtask
    task t_write;
        begin
            m.start_cond;
            wb(8'h94, 0);
            wb(8'h10, 0);
            wb(8'hab, 0);
            wb(8'hcd, 0);
            m.stop_cond;
            chk(pointer_out, 8'h12);
            chk(busy_out, 0);
            m.start_cond;
            wb(8'h94, 0);
            wb(8'h11, 0);
            m.stop_cond;
            chk(pointer_out, 8'h11);
            $display("test write done");
        end
    endtask
    task t_read;
        begin
            m.start_cond;
            wb(8'h94, 0);
            wb(8'h10, 0);
            m.start_cond;
            wb(8'h95, 0);
            rb(1'b0, 8'hab);
            rb(1'b1, 8'hcd);
            m.stop_cond;
            chk(pointer_out, 8'h12);
            $display("test read done");
        end
    endtask
    task t_other;
        begin
            m.start_cond;
            wb(8'h96, 1);
            wb(8'h00, 1);
            m.stop_cond;
            chk(pointer_out, 8'h12);
            $display("test other address done");
        end
    endtask
    initial begin
        resetn_in = 1'b0;
        enable_in = 1'b1;
        repeat (4) @(posedge clock_in);
        #1 resetn_in = 1'b1;
        repeat (4) @(posedge clock_in);
        #1;
        t_idle;
        t_write;
        t_read;
        t_other;
        wrap_up;
    end
endmodule // touch_sensor_i2c_slave_tb_top

// ### tb/tsi2c_checker.sv
// Checker for the serial slave port pins
`timescale 1ns/100ps
module tsi2c_checker #(
    parameter AW = 8
) (
    input wire clock_in,
    input wire resetn_in,
    input wire enable_in,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_n_out,
    input wire busy_out,
    input wire [AW-1:0] pointer_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    a_open_drain: assert property (!sda_oe_n_out |-> !sda_out)
        else $error("data pin driven high");
    a_idle_free: assert property (!busy_out |-> sda_oe_n_out)
        else $error("data held low while idle");
    a_start_seen: assert property (scl_in && $past(scl_in)
        && $fell(sda_in) |-> ##[1:8] busy_out)
        else $error("start not followed by busy");
    a_stop_seen: assert property (scl_in && $past(scl_in)
        && $rose(sda_in) |-> ##[1:8] !busy_out)
        else $error("stop not followed by idle");
    a_high_stable: assert property (scl_in [*3]
        |-> $stable(sda_oe_n_out))
        else $error("data drive moved while clock high");
    a_drive_low: assert property ($fell(sda_oe_n_out) |-> !scl_in)
        else $error("drive began while clock high");
    a_release_low: assert property ($rose(sda_oe_n_out) |-> !scl_in)
        else $error("release while clock high");
    a_ptr_idle: assert property (!busy_out && !$past(busy_out)
        |-> $stable(pointer_out))
        else $error("pointer moved while idle");
endmodule // tsi2c_checker

bind tsi2c_slave tsi2c_checker #(.AW(AW)) chk_i (.clock_in(clock_in),
    .resetn_in(resetn_in), .enable_in(enable_in), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .busy_out(busy_out), .pointer_out(pointer_out));

// ### tb/tsi2c_master.sv
// Bus master model pacing the serial clock and data line
`timescale 1ns/100ps
module tsi2c_master (
    output reg scl_out,
    output reg sda_low_out,
    input wire sda_in
);
    // Clock idles high between frames, data released
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // 320 ns bit with a 200 ns low phase: the slave's drive changes
    // about four clocks after a falling edge and must settle while low
    task xfer(input [7:0] tx, input mack, output [7:0] rx, output ack);
        integer i;
        for (i = 0; i < 9; i = i + 1) begin
            #80 sda_low_out = (i < 8) ? !tx[7-i] : !mack;
            #120 scl_out = 1'b1;
            #80 if (i < 8) rx[7-i] = sda_in;
            else ack = sda_in;
            #40 scl_out = 1'b0;
        end
    endtask
    task start_cond;
        begin
            #80 sda_low_out = 1'b0;
            #120 scl_out = 1'b1;
            #80 sda_low_out = 1'b1;
            #40 scl_out = 1'b0;
        end
    endtask
    // Trailing wait lets the slave see the STOP before anyone looks
    task stop_cond;
        begin
            #80 sda_low_out = 1'b1;
            #120 scl_out = 1'b1;
            #80 sda_low_out = 1'b0;
            #200;
        end
    endtask
endmodule // tsi2c_master
